/* File: rtl/tsm_pkg.sv */
package tsm_pkg;
  // Register byte offsets
  localparam logic [7:0] SLAVE_CFG_OFF   = 8'h08;
  localparam logic [7:0] DMA_IRQ_EN_OFF  = 8'h0C;
  localparam logic [7:0] FLAG_OFF        = 8'h10;
  localparam logic [7:0] CAPVAL_BASE_OFF = 8'h34;
  localparam logic [7:0] CHAN_CFG_OFF    = 8'h40;
  localparam logic [7:0] RUN_CTL_OFF     = 8'h44;
  localparam logic [7:0] COUNT_OFF       = 8'h48;

  // Enable register fields
  localparam int UPD_IRQ_BIT   = 0;
  localparam int CH_IRQ_LSB    = 1;
  localparam int TRG_IRQ_BIT   = 6;
  localparam int UPD_DMA_BIT   = 8;
  localparam int CH_DMA_LSB    = 9;
  localparam int TRG_DMA_BIT   = 14;

  // Flag register fields
  localparam int UPD_FLAG_BIT  = 0;
  localparam int CH_FLAG_LSB   = 1;
  localparam int TRG_FLAG_BIT  = 6;
  localparam int CH_OVF_LSB    = 9;

  // Slave config fields
  localparam int SMS_LSB       = 0;
  localparam int TRGSEL_LSB    = 4;

  localparam logic [31:0] EN_MASK   = 32'h00005F5F;
  localparam logic [31:0] FLAG_MASK = 32'h00001E5F;
  localparam logic [31:0] SCFG_MASK = 32'h00000077;
  localparam logic [31:0] ZERO_WORD = 32'h00000000;

  localparam int NUM_CH = 4;

  typedef enum logic [2:0] {
    SM_OFF     = 3'h0,
    SM_QUAD0   = 3'h1,
    SM_QUAD1   = 3'h2,
    SM_QUAD2   = 3'h3,
    SM_RESTART = 3'h4,
    SM_PAUSE   = 3'h5,
    SM_EVENT   = 3'h6,
    SM_EXTCLK0 = 3'h7
  } tsm_mode_t;
endpackage

/* File: rtl/tsm_sync.sv */
`timescale 1ns/100ps
// Three-stage synchroniser; output changes once stages 2 and 3 agree
module tsm_sync (
  // Clock and reset
  input  wire logic clk_sys,
  input  wire logic rst,
  // Data
  input  wire logic din,
  output logic      dout
);
  logic [2:0] stage_reg;

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      stage_reg <= 3'h0;
    end else begin
      stage_reg <= {stage_reg[1:0], din};
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      dout <= 1'b0;
    end else if (stage_reg[1] == stage_reg[2]) begin
      dout <= stage_reg[2];
    end
  end
endmodule // tsm_sync

/* File: rtl/tsm_capmem.sv */
`timescale 1ns/100ps
// Captured-value store, one word per channel, registered read
module tsm_capmem #(
  parameter int DEPTH = 4,
  parameter int WIDTH = 16,
  parameter int AW    = 2
) (
  // Clock
  input  wire logic             clk_sys,
  // Write port
  input  wire logic             wr_en,
  input  wire logic [AW-1:0]    wr_addr,
  input  wire logic [WIDTH-1:0] wr_data,
  // Read port
  input  wire logic [AW-1:0]    rd_addr,
  output logic      [WIDTH-1:0] rd_data
);
  logic [WIDTH-1:0] mem [DEPTH];

  always_ff @(posedge clk_sys) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

  always_ff @(posedge clk_sys) begin
    rd_data <= mem[rd_addr];
  end
endmodule // tsm_capmem

/* File: rtl/tsm_timer.sv */
`timescale 1ns/100ps
// Overview of operation
// - Mode 000: counter steps every kernel clock while run bit is set.
// - Mode 001: step on channel 0 edges, direction from channel 1 level.
// - Mode 010: step on channel 1 edges, direction from channel 0 level.
// - Mode 011: step on both channel edges, each level directing the other.
// - Mode 100: trigger rising edge reinitialises counter and raises update event.
// - Mode 101: counter clock runs only while trigger is high.
// - Mode 110: trigger rising edge sets the run bit.
// - Mode 111: counter steps on each trigger rising edge.
// - DMA requests gated by trigger, channel and update enable bits.
// - Interrupts gated by update, channel and trigger enable bits.
// - Input-mode capture while capture flag set raises over-capture flag.
// - Trigger flag on trigger events; both edges count in pause mode.
// - Capture/compare flag set on input capture or output compare match.
// - Reading captured value in input mode clears capture/compare flag.
// - Flags set by hardware only; software clears by writing zero.
// - Update flag set on every update event.
// - Three-bit trigger select picks internal, channel or external trigger.
module tsm_timer #(
  parameter int CNT_W = 16
) (
  // Clock and reset
  input  wire logic        clk_sys,
  input  wire logic        rst,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Channel and trigger inputs
  input  wire logic        chan0_filtered_input,
  input  wire logic        chan1_filtered_input,
  input  wire logic [3:0]  internal_trigger,
  input  wire logic        ext_trigger,
  // Capture and compare events from channels
  input  wire logic [3:0]  chan_capture_event,
  input  wire logic [3:0]  chan_compare_event,
  // Outputs
  output logic             irq,
  output logic             dma_trigger_req,
  output logic [3:0]       dma_chan_req,
  output logic             dma_update_req,
  output logic [CNT_W-1:0] count_out
);
  // Synchronised pins
  logic ci0_s, ci1_s, ext_s;
  logic [3:0] iti_s;

  tsm_sync u_sync_ci0 (.clk_sys(clk_sys), .rst(rst), .din(chan0_filtered_input), .dout(ci0_s));
  tsm_sync u_sync_ci1 (.clk_sys(clk_sys), .rst(rst), .din(chan1_filtered_input), .dout(ci1_s));
  tsm_sync u_sync_ext (.clk_sys(clk_sys), .rst(rst), .din(ext_trigger), .dout(ext_s));

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_iti
      tsm_sync u_sync_iti (.clk_sys(clk_sys), .rst(rst), .din(internal_trigger[gi]), .dout(iti_s[gi]));
    end
  endgenerate

  // Registers
  logic [31:0]      en_reg;
  logic [31:0]      flag_reg;
  logic [2:0]       mode_reg;
  logic [2:0]       trgsel_reg;
  logic [3:0]       chan_input_reg;
  logic             run_reg;
  logic [CNT_W-1:0] cnt_reg;
  logic             ci0_d_reg, ci1_d_reg, trg_d_reg;

  // APB decode
  logic access, wr, rd;
  assign access = psel && penable;
  assign wr     = access && pwrite;
  assign rd     = access && !pwrite;

  logic cap_hit;
  logic [1:0] cap_idx;
  assign cap_hit = (paddr >= tsm_pkg::CAPVAL_BASE_OFF) && (paddr < tsm_pkg::CHAN_CFG_OFF) && (paddr[1:0] == 2'h0);
  assign cap_idx = 2'((paddr - tsm_pkg::CAPVAL_BASE_OFF) >> 2);

  logic full_word;
  assign full_word = (pstrb == 4'hF);

  // Trigger selection
  logic trg;
  always_comb begin
    case (trgsel_reg)
      3'h0:    trg = iti_s[0];
      3'h1:    trg = iti_s[1];
      3'h2:    trg = iti_s[2];
      3'h3:    trg = iti_s[3];
      3'h4:    trg = ci0_s ^ ci0_d_reg;
      3'h5:    trg = ci0_s;
      3'h6:    trg = ci1_s;
      default: trg = ext_s;
    endcase
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      ci0_d_reg <= 1'b0;
      ci1_d_reg <= 1'b0;
      trg_d_reg <= 1'b0;
    end else begin
      ci0_d_reg <= ci0_s;
      ci1_d_reg <= ci1_s;
      trg_d_reg <= trg;
    end
  end

  logic trg_rise, trg_any, ci0_edge, ci1_edge;
  assign trg_rise = trg && !trg_d_reg;
  assign trg_any  = trg ^ trg_d_reg;
  assign ci0_edge = ci0_s ^ ci0_d_reg;
  assign ci1_edge = ci1_s ^ ci1_d_reg;

  tsm_pkg::tsm_mode_t mode;
  assign mode = tsm_pkg::tsm_mode_t'(mode_reg);

  // Counter step, direction, reinit and trigger event
  logic step, down, reinit, trg_event;
  always_comb begin
    step      = 1'b0;
    down      = 1'b0;
    reinit    = 1'b0;
    trg_event = 1'b0;
    case (mode)
      tsm_pkg::SM_OFF: begin
        step = run_reg;
      end
      tsm_pkg::SM_QUAD0: begin
        step = run_reg && ci0_edge;
        down = ci0_s ~^ ci1_s;
      end
      tsm_pkg::SM_QUAD1: begin
        step = run_reg && ci1_edge;
        down = ci0_s ^ ci1_s;
      end
      tsm_pkg::SM_QUAD2: begin
        step = run_reg && (ci0_edge || ci1_edge);
        down = ci0_edge ? (ci0_s ~^ ci1_s) : (ci0_s ^ ci1_s);
      end
      tsm_pkg::SM_RESTART: begin
        step      = run_reg;
        reinit    = trg_rise;
        trg_event = trg_rise;
      end
      tsm_pkg::SM_PAUSE: begin
        step      = run_reg && trg;
        trg_event = trg_any;
      end
      tsm_pkg::SM_EVENT: begin
        step      = run_reg;
        trg_event = trg_rise;
      end
      tsm_pkg::SM_EXTCLK0: begin
        step      = run_reg && trg_rise;
        trg_event = trg_rise;
      end
      default: begin
        step = 1'b0;
      end
    endcase
  end

  logic update_evt;
  assign update_evt = reinit;

  logic run_wr;
  assign run_wr = wr && (paddr == tsm_pkg::RUN_CTL_OFF);

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      run_reg <= 1'b0;
    end else if (mode == tsm_pkg::SM_EVENT && trg_rise) begin
      run_reg <= 1'b1;
    end else if (run_wr) begin
      run_reg <= pwdata[0];
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      cnt_reg <= '0;
    end else if (reinit) begin
      cnt_reg <= '0;
    end else if (step) begin
      cnt_reg <= down ? cnt_reg - 1'b1 : cnt_reg + 1'b1;
    end
  end

  // Configuration registers
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      mode_reg       <= 3'h0;
      trgsel_reg     <= 3'h0;
      en_reg         <= tsm_pkg::ZERO_WORD;
      chan_input_reg <= 4'h0;
    end else if (wr && full_word) begin
      if (paddr == tsm_pkg::SLAVE_CFG_OFF) begin
        mode_reg   <= pwdata[tsm_pkg::SMS_LSB +: 3];
        trgsel_reg <= pwdata[tsm_pkg::TRGSEL_LSB +: 3];
      end
      if (paddr == tsm_pkg::DMA_IRQ_EN_OFF) begin
        en_reg <= pwdata & tsm_pkg::EN_MASK;
      end
      if (paddr == tsm_pkg::CHAN_CFG_OFF) begin
        chan_input_reg <= pwdata[3:0];
      end
    end
  end

  // Capture memory
  logic [CNT_W-1:0] cap_rd;
  logic             cap_we;
  logic [1:0]       cap_wa;
  always_comb begin
    cap_we = 1'b0;
    cap_wa = 2'h0;
    for (int i = 0; i < tsm_pkg::NUM_CH; i++) begin
      if (chan_capture_event[i] && chan_input_reg[i] && !cap_we) begin
        cap_we = 1'b1;
        cap_wa = 2'(i);
      end
    end
  end

  tsm_capmem #(.DEPTH(tsm_pkg::NUM_CH), .WIDTH(CNT_W), .AW(2)) u_capmem (
    .clk_sys (clk_sys),
    .wr_en   (cap_we),
    .wr_addr (cap_wa),
    .wr_data (cnt_reg),
    .rd_addr (cap_idx),
    .rd_data (cap_rd)
  );

  // Flags: set wins over clear
  logic [31:0] flag_set, flag_clr;
  always_comb begin
    flag_set = tsm_pkg::ZERO_WORD;
    flag_clr = tsm_pkg::ZERO_WORD;
    flag_set[tsm_pkg::UPD_FLAG_BIT] = update_evt;
    flag_set[tsm_pkg::TRG_FLAG_BIT] = trg_event;
    for (int i = 0; i < tsm_pkg::NUM_CH; i++) begin
      flag_set[tsm_pkg::CH_FLAG_LSB + i] = chan_input_reg[i] ? chan_capture_event[i]
                                                             : chan_compare_event[i];
      flag_set[tsm_pkg::CH_OVF_LSB + i] = chan_input_reg[i] && chan_capture_event[i]
                                          && flag_reg[tsm_pkg::CH_FLAG_LSB + i];
      if (rd && cap_hit && cap_idx == 2'(i) && chan_input_reg[i]) begin
        flag_clr[tsm_pkg::CH_FLAG_LSB + i] = 1'b1;
      end
    end
    if (wr && full_word && paddr == tsm_pkg::FLAG_OFF) begin
      flag_clr = flag_clr | ~pwdata;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      flag_reg <= tsm_pkg::ZERO_WORD;
    end else begin
      flag_reg <= ((flag_reg & ~flag_clr) | flag_set) & tsm_pkg::FLAG_MASK;
    end
  end

  // Interrupt and DMA requests
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      irq <= 1'b0;
    end else begin
      irq <= |(flag_reg[6:0] & en_reg[6:0]);
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      dma_trigger_req <= 1'b0;
      dma_chan_req    <= 4'h0;
      dma_update_req  <= 1'b0;
    end else begin
      dma_trigger_req <= flag_reg[tsm_pkg::TRG_FLAG_BIT] && en_reg[tsm_pkg::TRG_DMA_BIT];
      dma_chan_req    <= flag_reg[tsm_pkg::CH_FLAG_LSB +: 4] & en_reg[tsm_pkg::CH_DMA_LSB +: 4];
      dma_update_req  <= flag_reg[tsm_pkg::UPD_FLAG_BIT] && en_reg[tsm_pkg::UPD_DMA_BIT];
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      count_out <= '0;
    end else begin
      count_out <= cnt_reg;
    end
  end

  // APB response: two-cycle access, capture read waits one more cycle
  logic cap_rd_setup;
  assign cap_rd_setup = psel && !penable && !pwrite && cap_hit;

  logic known;
  assign known = cap_hit || paddr == tsm_pkg::SLAVE_CFG_OFF || paddr == tsm_pkg::DMA_IRQ_EN_OFF
              || paddr == tsm_pkg::FLAG_OFF || paddr == tsm_pkg::CHAN_CFG_OFF
              || paddr == tsm_pkg::RUN_CTL_OFF || paddr == tsm_pkg::COUNT_OFF;

  logic [31:0] rdata;
  always_comb begin
    rdata = tsm_pkg::ZERO_WORD;
    if (cap_hit) begin
      rdata[CNT_W-1:0] = cap_rd;
    end else begin
      case (paddr)
        tsm_pkg::SLAVE_CFG_OFF:  rdata = {25'h0, trgsel_reg, 1'b0, mode_reg};
        tsm_pkg::DMA_IRQ_EN_OFF: rdata = en_reg;
        tsm_pkg::FLAG_OFF:       rdata = flag_reg;
        tsm_pkg::CHAN_CFG_OFF:   rdata = {28'h0, chan_input_reg};
        tsm_pkg::RUN_CTL_OFF:    rdata = {31'h0, run_reg};
        tsm_pkg::COUNT_OFF:      rdata[CNT_W-1:0] = cnt_reg;
        default:                 rdata = tsm_pkg::ZERO_WORD;
      endcase
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      pready  <= 1'b1;
      pslverr <= 1'b0;
      prdata  <= tsm_pkg::ZERO_WORD;
    end else begin
      pready  <= !cap_rd_setup;
      pslverr <= psel && !penable && !known;
      prdata  <= (psel && !pwrite) ? rdata : tsm_pkg::ZERO_WORD;
    end
  end
endmodule // tsm_timer

/* File: verif/tsm_qenc.sv */
`timescale 1ns/100ps
// Quadrature encoder: each step moves one phase in gray order
module tsm_qenc (
  // Clock and reset
  input  wire logic clk_sys,
  input  wire logic rst,
  // Step command
  input  wire logic step,
  input  wire logic dir,
  // Encoder phases
  output logic      q0,
  output logic      q1
);
  logic [1:0] ph_reg;

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      ph_reg <= 2'h0;
    end else if (step) begin
      ph_reg <= dir ? ph_reg - 2'h1 : ph_reg + 2'h1;
    end
  end

  assign q1 = ph_reg[1];
  assign q0 = ph_reg[1] ^ ph_reg[0];
endmodule // tsm_qenc

/* File: verif/tsm_timer_assertions.sv */
`timescale 1ns/100ps
// Enables and modes mirrored from APB writes
module tsm_timer_assertions (
  // Clock and reset
  input  wire logic        clk_sys,
  input  wire logic        rst,
  // APB
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  input  wire logic        pready,
  // Events and requests
  input  wire logic        ext_trigger,
  input  wire logic [3:0]  chan_capture_event,
  input  wire logic [3:0]  chan_compare_event,
  input  wire logic        irq,
  input  wire logic        dma_trigger_req,
  input  wire logic [3:0]  dma_chan_req,
  input  wire logic        dma_update_req
);
  logic        wr;
  logic [31:0] en_q;
  logic [6:0]  scfg_q;
  logic [3:0]  icfg_q;

  assign wr = psel && penable && pready && pwrite && pstrb == 4'hF;

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      en_q <= 32'h00000000;
      scfg_q <= 7'h00;
      icfg_q <= 4'h0;
    end else if (wr) begin
      if (paddr == tsm_pkg::DMA_IRQ_EN_OFF) en_q <= pwdata & tsm_pkg::EN_MASK;
      if (paddr == tsm_pkg::SLAVE_CFG_OFF) scfg_q <= pwdata[6:0];
      if (paddr == tsm_pkg::CHAN_CFG_OFF) icfg_q <= pwdata[3:0];
    end
  end

  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);

  sequence s_cap0;
    chan_capture_event[0] && icfg_q[0] && en_q[9] ##1 en_q[9];
  endsequence
  sequence s_ext_clk;
    $rose(ext_trigger) && scfg_q == 7'h77 && en_q[14] ##1 en_q[14] [*8];
  endsequence

  a_irq_masked: assert property (en_q[6:0] == 7'h00 && $past(en_q[6:0]) == 7'h00 |-> !irq)
    else $error("irq high with interrupt enables clear");
  a_upd_dma_masked: assert property (!en_q[8] && !$past(en_q[8]) |-> !dma_update_req)
    else $error("update dma request while disabled");
  a_trg_dma_masked: assert property (!en_q[14] && !$past(en_q[14]) |-> !dma_trigger_req)
    else $error("trigger dma request while disabled");
  a_chan_dma_masked: assert property (en_q[12:9] == 4'h0 && $past(en_q[12:9]) == 4'h0 |-> dma_chan_req == 4'h0)
    else $error("channel dma request while disabled");
  a_cap_raises_dma: assert property (s_cap0 |-> ##1 dma_chan_req[0])
    else $error("capture did not raise channel 0 request");
  a_cmp_raises_irq: assert property (chan_compare_event[1] && !icfg_q[1] && en_q[2] ##1 en_q[2] |-> ##1 irq)
    else $error("compare did not raise irq");
  a_trg_raises_dma: assert property (s_ext_clk |-> ##[0:6] dma_trigger_req)
    else $error("trigger edge did not raise trigger request");
  a_upd_flag_holds: assert property (dma_update_req && en_q[8] && !wr && !$past(wr) |=> dma_update_req)
    else $error("update request dropped without a write");
  a_trg_flag_holds: assert property (dma_trigger_req && en_q[14] && !wr && !$past(wr) |=> dma_trigger_req)
    else $error("trigger request dropped without a write");
endmodule // tsm_timer_assertions

bind tsm_timer tsm_timer_assertions u_chk (
  .clk_sys(clk_sys), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .pstrb(pstrb), .pready(pready), .ext_trigger(ext_trigger),
  .chan_capture_event(chan_capture_event), .chan_compare_event(chan_compare_event), .irq(irq),
  .dma_trigger_req(dma_trigger_req), .dma_chan_req(dma_chan_req), .dma_update_req(dma_update_req)
);

/* File: verif/tsm_timer_tb_top.sv */
`timescale 1ns/100ps
module tsm_timer_tb_top;
  logic        clk_sys = 1'b0;
  logic        rst     = 1'b1;
  logic        psel    = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite  = 1'b0;
  logic [7:0]  paddr   = 8'h00;
  logic [31:0] pwdata  = 32'h00000000;
  logic [3:0]  itrg    = 4'h0;
  logic        ext_trg = 1'b0;
  logic [3:0]  cap_ev  = 4'h0;
  logic [3:0]  cmp_ev  = 4'h0;
  logic        step    = 1'b0;
  logic        dir     = 1'b0;
  logic [31:0] seed    = 32'h00000050;
  logic [31:0] prdata, r, v;
  logic        pready, pslverr, err, q0, q1, irq, dma_t, dma_u;
  logic [3:0]  dma_c;
  logic [15:0] cnt, c0, d, e;
  int          n_mismatch = 0;
  int          check_count = 0;
  int          n;

  always #20 clk_sys = ~clk_sys;

  tsm_timer u_dut (
    .clk_sys(clk_sys), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .pstrb(4'hF),
    .chan0_filtered_input(q0), .chan1_filtered_input(q1), .internal_trigger(itrg), .ext_trigger(ext_trg),
    .chan_capture_event(cap_ev), .chan_compare_event(cmp_ev), .irq(irq), .dma_trigger_req(dma_t),
    .dma_chan_req(dma_c), .dma_update_req(dma_u), .count_out(cnt)
  );
  tsm_qenc u_enc (.clk_sys(clk_sys), .rst(rst), .step(step), .dir(dir), .q0(q0), .q1(q1));

  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  function automatic logic [31:0] bit_of(input int b);
    return 32'h1 << b;
  endfunction
  // Counted edges: both phases in mode 3, one phase otherwise
  function automatic logic [15:0] qexp(input int m, input int k);
    return (m == 3) ? 16'(k) : 16'(k / 2);
  endfunction

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] dv);
    @(posedge clk_sys);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= dv;
    @(posedge clk_sys);
    penable <= 1'b1;
    @(posedge clk_sys);
    while (pready !== 1'b1) @(posedge clk_sys);
    r = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic pulse(input int i);
    @(posedge clk_sys);
    itrg <= (i < 4) ? 4'(1 << i) : 4'h0;
    ext_trg <= (i == 4);
    repeat (6) @(posedge clk_sys);
    itrg <= 4'h0;
    ext_trg <= 1'b0;
    repeat (6) @(posedge clk_sys);
  endtask
  task automatic ev(input logic [3:0] cm, input logic [3:0] pm);
    @(posedge clk_sys);
    cap_ev <= cm;
    cmp_ev <= pm;
    @(posedge clk_sys);
    cap_ev <= 4'h0;
    cmp_ev <= 4'h0;
    repeat (2) @(posedge clk_sys);
  endtask
  task automatic qstep(input logic dv);
    @(posedge clk_sys);
    step <= 1'b1;
    dir <= dv;
    @(posedge clk_sys);
    step <= 1'b0;
    repeat (6) @(posedge clk_sys);
  endtask
  task automatic summarize();
    $display("checks=%0d mismatches=%0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  initial begin
    repeat (30000) @(posedge clk_sys);
    n_mismatch++;
    summarize();
  end

  initial begin
    repeat (6) @(posedge clk_sys);
    rst <= 1'b0;
    apb(1'b0, tsm_pkg::DMA_IRQ_EN_OFF, 32'h0);
    cmp(r, 32'h0);
    apb(1'b0, tsm_pkg::FLAG_OFF, 32'h0);
    cmp(r, 32'h0);
    apb(1'b0, 8'h20, 32'h0);
    cmp({31'h0, err}, 32'h1);
    v = xs();
    apb(1'b1, tsm_pkg::DMA_IRQ_EN_OFF, v);
    apb(1'b0, tsm_pkg::DMA_IRQ_EN_OFF, 32'h0);
    cmp(r, v & tsm_pkg::EN_MASK);
    apb(1'b1, tsm_pkg::DMA_IRQ_EN_OFF, 32'hFFFFFFFF);
    apb(1'b1, tsm_pkg::CHAN_CFG_OFF, 32'h1);
    ev(4'h1, 4'h0);
    apb(1'b0, tsm_pkg::FLAG_OFF, 32'h0);
    cmp(r, bit_of(1));
    cmp({28'h0, dma_c}, 32'h1);
    ev(4'h1, 4'h0);
    apb(1'b0, tsm_pkg::FLAG_OFF, 32'h0);
    cmp(r, bit_of(1) | bit_of(9));
    apb(1'b0, tsm_pkg::CAPVAL_BASE_OFF, 32'h0);
    apb(1'b0, tsm_pkg::FLAG_OFF, 32'h0);
    cmp(r, bit_of(9));
    apb(1'b1, tsm_pkg::FLAG_OFF, 32'hFFFFFDFF);
    apb(1'b0, tsm_pkg::FLAG_OFF, 32'h0);
    cmp(r, 32'h0);
    ev(4'h0, 4'h2);
    apb(1'b0, tsm_pkg::FLAG_OFF, 32'h0);
    cmp(r, bit_of(2));
    cmp({31'h0, irq}, 32'h1);
    apb(1'b1, tsm_pkg::FLAG_OFF, 32'h0);
    repeat (2) @(posedge clk_sys);
    cmp({31'h0, irq}, 32'h0);
    apb(1'b1, tsm_pkg::RUN_CTL_OFF, 32'h1);
    repeat (2) @(posedge clk_sys);
    c0 = cnt;
    repeat (10) @(posedge clk_sys);
    cmp({16'h0, cnt - c0}, 32'hA);
    for (int k = 0; k < 5; k++) begin
      apb(1'b1, tsm_pkg::SLAVE_CFG_OFF, (k == 4) ? 32'h77 : 32'h07 | (32'(k) << 4));
      apb(1'b1, tsm_pkg::FLAG_OFF, 32'h0);
      n = 1 + xs() % 4;
      c0 = cnt;
      repeat (n) pulse(k);
      cmp({16'h0, cnt - c0}, 32'(n));
      apb(1'b0, tsm_pkg::FLAG_OFF, 32'h0);
      cmp(r & bit_of(6), bit_of(6));
      cmp({31'h0, dma_t}, 32'h1);
    end
    for (int m = 1; m < 4; m++) begin
      apb(1'b1, tsm_pkg::SLAVE_CFG_OFF, 32'(m));
      n = 4 + 2 * (xs() % 3);
      c0 = cnt;
      repeat (n) qstep(1'b0);
      repeat (2) @(posedge clk_sys);
      d = cnt - c0;
      e = qexp(m, n);
      cmp(32'((d == e) || (d == 16'(-e))), 32'h1);
      repeat (n) qstep(1'b1);
      repeat (2) @(posedge clk_sys);
      cmp({16'h0, cnt}, {16'h0, c0});
    end
    apb(1'b1, tsm_pkg::SLAVE_CFG_OFF, 32'h74);
    repeat (40) @(posedge clk_sys);
    apb(1'b1, tsm_pkg::FLAG_OFF, 32'h0);
    pulse(4);
    cmp(32'(cnt < 16'h0010), 32'h1);
    cmp({31'h0, dma_u}, 32'h1);
    apb(1'b0, tsm_pkg::FLAG_OFF, 32'h0);
    cmp(r & bit_of(0), bit_of(0));
    apb(1'b1, tsm_pkg::SLAVE_CFG_OFF, 32'h75);
    repeat (3) @(posedge clk_sys);
    c0 = cnt;
    repeat (20) @(posedge clk_sys);
    cmp({16'h0, cnt}, {16'h0, c0});
    ext_trg <= 1'b1;
    repeat (20) @(posedge clk_sys);
    cmp(32'(cnt != c0), 32'h1);
    apb(1'b1, tsm_pkg::FLAG_OFF, 32'h0);
    @(posedge clk_sys);
    ext_trg <= 1'b0;
    repeat (10) @(posedge clk_sys);
    apb(1'b0, tsm_pkg::FLAG_OFF, 32'h0);
    cmp(r & bit_of(6), bit_of(6));
    apb(1'b1, tsm_pkg::RUN_CTL_OFF, 32'h0);
    apb(1'b1, tsm_pkg::SLAVE_CFG_OFF, 32'h76);
    pulse(4);
    apb(1'b0, tsm_pkg::RUN_CTL_OFF, 32'h0);
    cmp(r & 32'h1, 32'h1);
    summarize();
  end
endmodule // tsm_timer_tb_top
